// ===== bench/adcc_core_model.sv
// stand-in for the analog core: the result code follows the selected channel
// assumes the control block samples only while a conversion is active
`timescale 1ns/1ps
module adcc_core_model (
  // from control
  input wire [3:0] channel_select,
  input wire conv_active,
  // to control
  output logic [9:0] conv_result
);
  // outside a conversion the inverse shows, so a stray capture is caught
  assign conv_result = conv_active ? {channel_select[1:0], 4'h5, channel_select} :
    ~{channel_select[1:0], 4'h5, channel_select};
endmodule // adcc_core_model

// ===== bench/adcc_top_asserts.sv
// checker for bus, conversion and interrupt timing at the top ports
// assumes a bind to adcc_top, one clock domain
`timescale 1ns/1ps
module adcc_top_asserts (
  // clock and reset
  input logic CLK_SYS,
  input logic RESET,
  // register bus
  input logic WB_CYC_I,
  input logic WB_STB_I,
  input logic WB_WE_I,
  input logic [4:0] WB_ADR_I,
  input logic [31:0] WB_DAT_O,
  input logic WB_ACK_O,
  // core and interrupt
  input logic [3:0] CHANNEL_SELECT,
  input logic CONV_ACTIVE,
  input logic CONV_SAMPLE,
  input logic CONV_CLK_EN,
  input logic HIGH_SPEED_MODE,
  input logic CONV_DONE_IRQ,
  input logic IRQ_VECTOR_ACK
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  ack_one_shot_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  ack_on_take_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
  data_upper_zero_a: assert property (WB_DAT_O[31:8] == 24'h00_0000) else $error("read data upper bits set");
  chan_frozen_a: assert property (CONV_ACTIVE && $past(CONV_ACTIVE) |-> $stable(CHANNEL_SELECT))
    else $error("channel changed mid conversion");
  conv_min_len_a: assert property ($rose(CONV_ACTIVE) |-> CONV_ACTIVE [*8])
    else $error("conversion too short");
  tick_spacing_a: assert property (CONV_CLK_EN |=> !CONV_CLK_EN) else $error("ticks too close");
  vector_clear_a: assert property (IRQ_VECTOR_ACK |=> !CONV_DONE_IRQ || CONV_SAMPLE)
    else $error("irq survives vector ack");
  hsm_by_write_a: assert property ($changed(HIGH_SPEED_MODE) |-> $past(WB_WE_I && WB_ADR_I == 5'h08) ||
    $past(WB_WE_I && WB_ADR_I == 5'h08, 2) || $past(WB_WE_I && WB_ADR_I == 5'h08, 3))
    else $error("speed mode changed without write");
endmodule // adcc_top_asserts

// ===== bench/tb_adcc_top.sv
// self-checking bench: register access, conversions, result lock, triggers
// assumes the core model and checker compiled before it
`timescale 1ns/1ps
module tb_adcc_top;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, vack = 0;
  logic [4:0] adr = 0;
  logic [31:0] dwr = 0;
  logic [12:0] trg = 0;
  logic [7:0] q;
  wire [31:0] drd;
  wire [9:0] res;
  wire [3:0] ch;
  wire ack, act, smp, cken, hsm, irq;
  int num_errors = 0, n_compared = 0, c1, c2, n;
  always #5 clk = ~clk;
  adcc_top dut (.CLK_SYS(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'h1), .WB_DAT_I(dwr), .WB_DAT_O(drd), .WB_ACK_O(ack), .CHANNEL_SELECT(ch), .CONV_ACTIVE(act),
    .CONV_SAMPLE(smp), .CONV_CLK_EN(cken), .HIGH_SPEED_MODE(hsm), .CONV_RESULT(res), .TRIGGER_SRC(trg),
    .CONV_DONE_IRQ(irq), .IRQ_VECTOR_ACK(vack));
  adcc_core_model core (.channel_select(ch), .conv_active(act), .conv_result(res));
  task results;
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task fail(input string m);
    num_errors++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
      fail($sformatf("got %h want %h", g, e));
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int i;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dwr <= {24'h00_0000, d};
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1)
    begin
      fail("no ack");
      results();
    end
    q = drd[7:0];
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task rd(input logic [4:0] a, input logic [7:0] e);
    bus(0, a, 8'h00);
    chk(q, e);
  endtask
  task wait_sig(input int sel, input int lim, output int k);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while ((sel ? smp : cken) !== 1'b1 && k < lim);
    if (k == lim)
    begin
      fail("wait ran out");
      results();
    end
  endtask
  task pulse_vack;
    @(posedge clk);
    vack <= 1;
    @(posedge clk);
    vack <= 0;
    @(negedge clk);
    chk(irq, 0);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 0;
    for (int a = 0; a < 6; a++)
      rd(a * 4, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 5'h04, 8'hC0 | c);
      wait_sig(0, 300, n);
      wait_sig(0, 300, n);
      chk(n, c < 2 ? 2 : 1 << c);
      wait_sig(1, 4000, n);
    end
    bus(1, 5'h08, 8'h80);
    repeat (2) @(negedge clk);
    chk(hsm, 1);
    rd(5'h08, 8'h80);
    bus(1, 5'h08, 8'h00);
    bus(1, 5'h04, 8'h10);
    bus(1, 5'h00, 8'h03);
    bus(1, 5'h04, 8'hC8);
    wait_sig(1, 2000, c1);
    chk(irq, 1);
    chk(ch, 4'h3);
    rd(5'h04, 8'h98);
    pulse_vack();
    rd(5'h0C, 8'h53);
    bus(1, 5'h00, 8'h0C);
    bus(1, 5'h04, 8'hC8);
    bus(1, 5'h00, 8'h0E);
    wait_sig(1, 2000, c2);
    chk(c1 > c2 + 20, 1);
    rd(5'h10, 8'h03);
    chk(ch, 4'hE);
    bus(1, 5'h04, 8'h98);
    rd(5'h04, 8'h88);
    bus(1, 5'h04, 8'hC8);
    wait_sig(1, 2000, n);
    rd(5'h0C, 8'h5E);
    rd(5'h10, 8'h02);
    bus(1, 5'h00, 8'h2E);
    rd(5'h10, 8'h97);
    rd(5'h0C, 8'h80);
    pulse_vack();
    bus(1, 5'h00, 8'h0B);
    bus(1, 5'h08, 8'h10);
    wait_sig(1, 2000, n);
    chk(ch, 4'hB);
    rd(5'h08, 8'h00);
    bus(1, 5'h04, 8'hC8);
    wait_sig(1, 2000, n);
    bus(1, 5'h08, 8'h01);
    bus(1, 5'h04, 8'hA0);
    @(posedge clk);
    trg <= 13'h0002;
    wait_sig(1, 2000, n);
    trg <= 13'h0000;
    results();
  end
endmodule // tb_adcc_top
bind adcc_top adcc_top_asserts u_chk (.CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CHANNEL_SELECT(CHANNEL_SELECT), .CONV_ACTIVE(CONV_ACTIVE), .CONV_SAMPLE(CONV_SAMPLE), .CONV_CLK_EN(CONV_CLK_EN),
  .HIGH_SPEED_MODE(HIGH_SPEED_MODE), .CONV_DONE_IRQ(CONV_DONE_IRQ), .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK));

// ===== design/adcc_defs.vh
// register map, field positions and timing constants of the converter control block
// assumes an 8-bit register file behind a classic wishbone slave, word aligned
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// ----------------------------------------
// register byte addresses (word aligned)
// ----------------------------------------
`define ADCC_OFS_CHSEL 4'h0
`define ADCC_OFS_CSA 4'h4
`define ADCC_OFS_CSB 4'h8
`define ADCC_OFS_RESL 4'hC
`define ADCC_OFS_RESH 4'h0
`define ADCC_PAGE_RESH 1'b1

// ----------------------------------------
// field positions
// ----------------------------------------
`define ADCC_CSA_EN 7
`define ADCC_CSA_START 6
`define ADCC_CSA_AUTO 5
`define ADCC_CSA_DONE 4
`define ADCC_CSA_IE 3
`define ADCC_CSB_HSM 7
`define ADCC_CSB_AMPREQ 4
`define ADCC_CHSEL_LEFT 5

// ----------------------------------------
// codes and counts
// ----------------------------------------
`define ADCC_CH_RESERVED 4'h0D
`define ADCC_TS_FREE 4'h0
`define ADCC_TS_PSC0 4'h8
`define ADCC_TS_PSC2 4'hA
`define ADCC_TS_LAST 4'hC
`define ADCC_CONV_CYCLES 5'h0D
`define ADCC_INIT_CYCLES 5'h0C
`define ADCC_RESET_8 8'h00

`endif

// ===== design/adcc_top.v
// converter control: channel select, control/status a and b, prescaler, result registers
// assumes a wishbone classic master on CLK_SYS and an analog core that returns a 10-bit sample
//
// Function
// - channel codes 0-10 single, 11 amplified_channel_zero, 12 amplified_channel_one, 14 bandgap, 15 ground, 13 reserved.
// - channel field changes during a conversion apply only once it completes.
// - enable bit; clearing it mid-conversion disables only after that conversion.
// - writing one to start begins a conversion; hardware clears it; zero ignored.
// - first conversion after enable also runs the initialisation sequence.
// - auto-trigger bit selects triggered mode using the trigger source field.
// - done flag set when conversion ends; result registers updated there unless held after a low byte read.
// - done flag cleared by interrupt vector acknowledge or writing one.
// - interrupt enable bit gates the end-of-conversion interrupt request.
// - prescaler codes 0,1 divide by 2, doubling each code up to 128.
// - high-speed mode bit in control register b, for converter clock above 200KHz.
// - amplified start request bit; hardware clears it on start, software may clear.
// - trigger source field used only in auto mode; codes 13-15 reserved.
// - auto mode starts on the rising edge of the selected source flag.
// - power-stage async triggers start on each event when previous conversion done.
// - after low byte read, results held until high byte read.
// - right or left adjusted 10-bit result layout, unused bits zero.
// - alignment bit changes result layout immediately, even mid-conversion.
// - normal conversion takes 13 converter clocks from next prescaled edge.
`timescale 1ns/1ps
`include "adcc_defs.vh"

module adcc_top #(
  parameter RES_W = 10
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RESET,
  // wishbone classic slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [4:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // analog core
  output reg [3:0] CHANNEL_SELECT,
  output reg CONV_ACTIVE,
  output reg CONV_SAMPLE,
  output wire CONV_CLK_EN,
  output reg HIGH_SPEED_MODE,
  input wire [RES_W-1:0] CONV_RESULT,
  // trigger sources, bit n = trigger code n, from other clock domains
  input wire [12:0] TRIGGER_SRC,
  // interrupt handshake with the cpu
  output wire CONV_DONE_IRQ,
  input wire IRQ_VECTOR_ACK
);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  // conversion sequencer
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg need_init_ff;
  reg [4:0] cyc_ff;
  reg [6:0] pre_ff;
  // channel selection register fields
  reg [3:0] chsel_ff;
  reg left_ff;
  // control/status a fields
  reg en_ff;
  reg start_ff;
  reg auto_ff;
  reg done_ff;
  reg ie_ff;
  reg [2:0] psel_ff;
  // control/status b fields
  reg hsm_ff;
  reg ampreq_ff;
  reg [3:0] tsel_ff;
  // result and its read lock
  reg [RES_W-1:0] res_ff;
  reg lock_ff;
  // trigger synchroniser and edge history
  reg [12:0] trg_s1_ff;
  reg [12:0] trg_s2_ff;
  reg [12:0] trg_s3_ff;

  wire acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr = acc & WB_WE_I & WB_SEL_I[0];
  wire rd = acc & ~WB_WE_I;
  wire [4:0] adr = WB_ADR_I;
  wire sel_ch = (adr == {1'b0, `ADCC_OFS_CHSEL});
  wire sel_a = (adr == {1'b0, `ADCC_OFS_CSA});
  wire sel_b = (adr == {1'b0, `ADCC_OFS_CSB});
  wire sel_l = (adr == {1'b0, `ADCC_OFS_RESL});
  wire sel_h = (adr == {`ADCC_PAGE_RESH, `ADCC_OFS_RESH});
  wire [7:0] wd = WB_DAT_I[7:0];

  // enable as seen by the prescaler: a running conversion still finishes
  // after software clears the enable bit
  wire en_eff = en_ff | (state_ff != ST_IDLE);

  // ----------------------------------------
  // prescaler: divisor 2^max(code,1)
  // ----------------------------------------
  function [6:0] pre_mask;
    input [2:0] code;
    begin
      if (code == 3'h0)
        pre_mask = 7'h01;
      else
        pre_mask = (7'h7F >> (3'h7 - code));
    end
  endfunction

  wire pre_tick = ((pre_ff & pre_mask(psel_ff)) == pre_mask(psel_ff));
  assign CONV_CLK_EN = pre_tick & en_eff;

  // ----------------------------------------
  // result layout
  // ----------------------------------------
  // alignment is applied on read, so flipping it reshapes a held result at once
  function [7:0] res_low;
    input [RES_W-1:0] r;
    input left;
    begin
      if (left)
        res_low = {r[1:0], 6'h00};
      else
        res_low = r[7:0];
    end
  endfunction

  function [7:0] res_high;
    input [RES_W-1:0] r;
    input left;
    begin
      if (left)
        res_high = r[9:2];
      else
        res_high = {6'h00, r[9:8]};
    end
  endfunction

  // ----------------------------------------
  // trigger synchroniser
  // ----------------------------------------
  // sources come from other clock domains; logic reads only the later stages
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      trg_s1_ff <= 13'h0000;
      trg_s2_ff <= 13'h0000;
      trg_s3_ff <= 13'h0000;
    end
    else
    begin
      trg_s1_ff <= TRIGGER_SRC;
      trg_s2_ff <= trg_s1_ff;
      trg_s3_ff <= trg_s2_ff;
    end
  end

  // ----------------------------------------
  // trigger edge detection after two flops
  // ----------------------------------------
  wire [12:0] trg_rise = trg_s2_ff & ~trg_s3_ff;
  wire ts_valid = (tsel_ff <= `ADCC_TS_LAST) && (tsel_ff != `ADCC_TS_FREE);
  wire ts_async = (tsel_ff >= `ADCC_TS_PSC0) && (tsel_ff <= `ADCC_TS_PSC2);
  // async events gated to converter idle here; flag edges also start only from idle, via the sequencer and start bit
  wire trig_hit = auto_ff & ts_valid & trg_rise[tsel_ff] & (~ts_async | (state_ff == ST_IDLE));
  wire free_hit = auto_ff & (tsel_ff == `ADCC_TS_FREE) & (state_ff == ST_IDLE) & done_ff;
  wire finish = (state_ff == ST_CONV) & CONV_CLK_EN & (cyc_ff == 5'h01);
  wire wr_start = wr & sel_a & wd[`ADCC_CSA_START];
  wire wr_amp = wr & sel_b & wd[`ADCC_CSB_AMPREQ];

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (en_ff & (start_ff | ampreq_ff | trig_hit | free_hit))
          nxt_state = ST_WAIT;
      ST_WAIT:
        if (CONV_CLK_EN)
          nxt_state = ST_CONV;
      ST_CONV:
        if (finish)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      state_ff <= ST_IDLE;
      chsel_ff <= 4'h0;
      left_ff <= 1'b0;
      en_ff <= 1'b0;
      start_ff <= 1'b0;
      auto_ff <= 1'b0;
      done_ff <= 1'b0;
      ie_ff <= 1'b0;
      psel_ff <= 3'h0;
      hsm_ff <= 1'b0;
      ampreq_ff <= 1'b0;
      tsel_ff <= 4'h0;
      res_ff <= {RES_W{1'b0}};
      need_init_ff <= 1'b1;
      pre_ff <= 7'h00;
      cyc_ff <= 5'h00;
      CHANNEL_SELECT <= 4'h0;
      CONV_ACTIVE <= 1'b0;
      CONV_SAMPLE <= 1'b0;
      HIGH_SPEED_MODE <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pre_ff <= (en_eff && state_ff != ST_IDLE) ? pre_ff + 7'h01 : 7'h00;
      HIGH_SPEED_MODE <= hsm_ff;
      CONV_SAMPLE <= 1'b0;
      // register writes
      if (wr & sel_ch)
      begin
        chsel_ff <= wd[3:0];
        left_ff <= wd[`ADCC_CHSEL_LEFT];
      end
      if (wr & sel_a)
      begin
        en_ff <= wd[`ADCC_CSA_EN];
        auto_ff <= wd[`ADCC_CSA_AUTO];
        ie_ff <= wd[`ADCC_CSA_IE];
        psel_ff <= wd[2:0];
      end
      if (wr & sel_b)
      begin
        hsm_ff <= wd[`ADCC_CSB_HSM];
        tsel_ff <= wd[3:0];
      end
      if (wr & sel_a & ~wd[`ADCC_CSA_EN] & (state_ff == ST_IDLE))
        need_init_ff <= 1'b1;
      // start bit: writing zero is ignored, hardware clears at finish
      if (finish)
        start_ff <= 1'b0;
      else if (wr_start)
        start_ff <= 1'b1;
      else if ((trig_hit | free_hit) & en_ff & (state_ff == ST_IDLE))
        start_ff <= 1'b1;
      // amplified request: set by software, cleared on start or by writing zero
      if (wr_amp)
        ampreq_ff <= 1'b1;
      else if (wr & sel_b)
        ampreq_ff <= 1'b0;
      else if (state_ff == ST_WAIT && CONV_CLK_EN)
        ampreq_ff <= 1'b0;
      // start of a conversion, channel latched here
      if (state_ff == ST_WAIT && CONV_CLK_EN)
      begin
        CHANNEL_SELECT <= chsel_ff;
        CONV_ACTIVE <= 1'b1;
        cyc_ff <= need_init_ff ? (`ADCC_CONV_CYCLES + `ADCC_INIT_CYCLES) : `ADCC_CONV_CYCLES;
        need_init_ff <= 1'b0;
      end
      else if (state_ff == ST_CONV && CONV_CLK_EN)
        cyc_ff <= cyc_ff - 5'h01;
      // idle channel follows the register so the mux settles early
      if (state_ff == ST_IDLE)
        CHANNEL_SELECT <= chsel_ff;
      // done flag: set wins over clear
      if (finish)
      begin
        CONV_ACTIVE <= 1'b0;
        CONV_SAMPLE <= 1'b1;
        done_ff <= 1'b1;
        if (~lock_ff)
          res_ff <= CONV_RESULT;
      end
      else if (IRQ_VECTOR_ACK | (wr & sel_a & wd[`ADCC_CSA_DONE]))
        done_ff <= 1'b0;
      // disable after the running conversion ends
      if (~en_ff & (state_ff == ST_IDLE))
        need_init_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // result read lock
  // ----------------------------------------
  // a low-byte read freezes the result so the high byte still belongs to it
  always @(posedge CLK_SYS)
  begin
    if (RESET)
      lock_ff <= 1'b0;
    else if (rd & sel_l)
      lock_ff <= 1'b1;
    else if (rd & sel_h)
      lock_ff <= 1'b0;
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // ack and data one cycle after the request is taken; data is zero otherwise
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= acc;
      WB_DAT_O <= 32'h0000_0000;
      if (rd)
      begin
        if (sel_ch)
          WB_DAT_O[7:0] <= {2'b00, left_ff, 1'b0, chsel_ff};
        else if (sel_a)
          WB_DAT_O[7:0] <= {en_ff, start_ff, auto_ff, done_ff, ie_ff, psel_ff};
        else if (sel_b)
          WB_DAT_O[7:0] <= {hsm_ff, 2'b00, ampreq_ff, tsel_ff};
        else if (sel_l)
          WB_DAT_O[7:0] <= res_low(res_ff, left_ff);
        else if (sel_h)
          WB_DAT_O[7:0] <= res_high(res_ff, left_ff);
      end
    end
  end

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  assign CONV_DONE_IRQ = done_ff & ie_ff;

endmodule // adcc_top
